// ---- rtl/led_ctrl_pkg.sv ----
// Shared constants and carrier types for the LED driver control sequencer.
// Assumes a single 40 MHz system clock and comparator flags sampled on it.
package led_ctrl_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 40000000;
  localparam int SW_FREQ_HZ_DEF = 400000;
  localparam int PERIOD_NOM_DEF = CLK_HZ / SW_FREQ_HZ_DEF;
  localparam int BLANK_US = 650;
  localparam int BLANK_CYCLES_DEF = BLANK_US * (CLK_HZ / 1000000);

  // ----------------------------------------------------------------
  // Spread spectrum
  // ----------------------------------------------------------------
  localparam int SWEEP_LO_PCT = 94;
  localparam int SWEEP_HI_PCT = 106;
  localparam int MOD_PERMIL = 2;
  localparam int SWEEP_HALF = 1000 / MOD_PERMIL / 2;

  // ----------------------------------------------------------------
  // Analog dimming ramp, millivolts
  // ----------------------------------------------------------------
  localparam int DIM_OFFSET_MV = 205;
  localparam int DIM_SPAN_MV = 2800;
  localparam int DIM_STEP_MV = 10;
  localparam int DIM_STEPS = DIM_SPAN_MV / DIM_STEP_MV;

  // ----------------------------------------------------------------
  // Slope compensation
  // ----------------------------------------------------------------
  localparam logic [11:0] SLOPE_BUCK_SLOW_MA_US = 12'h232;
  localparam logic [11:0] SLOPE_BUCK_FAST_MA_US = 12'hb54;
  localparam logic [11:0] SLOPE_BB_PERMIL_PER_V = 12'h04e;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic bias_uv;
    logic vin_above_bb_on;
    logic vin_above_bb_off;
    logic vin_above_buck_on;
    logic vin_above_buck_off;
    logic vin_above_ov_trip;
    logic vin_above_ov_release;
    logic temp_above_trip;
    logic temp_above_release;
    logic hs_overcurrent;
    logic pwm_trip;
    logic out_below_short;
    logic comp_above_limit;
    logic out_above_ov;
    logic out_below_release;
  } cmp_s;

  typedef struct packed {
    logic hs_on;
    logic ls_on;
    logic hi_z;
  } gate_s;

endpackage : led_ctrl_pkg

// ---- rtl/sw_osc.sv ----
// Switching oscillator with triangular spread-spectrum period sweep.
// Assumes restart is a one-cycle pulse in the system clock domain.
`timescale 1ns/1ps
module sw_osc #(
  parameter int PERIOD_NOM = led_ctrl_pkg::PERIOD_NOM_DEF
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic restart,
  output logic cycle_start,
  output logic [15:0] period
);
  import led_ctrl_pkg::*;

  localparam int P_MIN = PERIOD_NOM * 100 / SWEEP_HI_PCT;
  localparam int P_MAX = PERIOD_NOM * 100 / SWEEP_LO_PCT;

  if (P_MIN < 4 || P_MAX > 65535) begin : g_bad_period
    $error("sw_osc: nominal period out of range");
  end

  logic [15:0] cnt;
  logic [8:0] tri_pos;
  logic tri_up;
  logic wrap;
  logic [15:0] next_period;

  // ----------------------------------------------------------------
  // Period counter
  // ----------------------------------------------------------------
  assign wrap = (cnt >= period - 16'h0001);
  assign cycle_start = clk_en && (restart || wrap);

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cnt <= 16'h0000;
    end else if (clk_en) begin
      if (restart || wrap) begin
        cnt <= 16'h0000;
      end else begin
        cnt <= cnt + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Triangle sweep
  // ----------------------------------------------------------------
  always_comb begin
    next_period = 16'(P_MAX - (int'(tri_pos) * (P_MAX - P_MIN)) / SWEEP_HALF);
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      tri_pos <= 9'h000;
      tri_up <= 1'b1;
      period <= 16'(P_MAX);
    end else if (clk_en && cycle_start) begin
      period <= next_period;
      if (tri_up) begin
        if (tri_pos == 9'(SWEEP_HALF - 1)) begin
          tri_up <= 1'b0;
        end
        tri_pos <= tri_pos + 9'h001;
      end else begin
        if (tri_pos == 9'h001) begin
          tri_up <= 1'b1;
        end
        tri_pos <= tri_pos - 9'h001;
      end
    end
  end

  property p_period_bounds;
    @(posedge sys_clk) disable iff (!reset_n)
    (period >= 16'(P_MIN)) && (period <= 16'(P_MAX));
  endproperty
  a_period_bounds: assert property (p_period_bounds)
    else $error("Switching period left sweep bounds");

  property p_tri_bounds;
    @(posedge sys_clk) disable iff (!reset_n)
    tri_pos <= 9'(SWEEP_HALF);
  endproperty
  a_tri_bounds: assert property (p_tri_bounds)
    else $error("Sweep position beyond half modulation period");

endmodule : sw_osc

// ---- rtl/led_driver_protect_dim_ctrl.sv ----
// Protection and dimming sequencer for a synchronous LED driver.
// Assumes comparator flags and dimming input are synchronous to sys_clk.
`timescale 1ns/1ps
// Behaviour
// - Stop switching on bias undervoltage
// - Buck-boost input lockout with hysteresis
// - Buck input lockout with own thresholds
// - Overcurrent kills high side until next cycle
// - Slope rate fixed in buck, proportional otherwise
// - Triangular frequency sweep between low and high
// - Sweep repeats at fixed fraction of frequency
// - Input overvoltage stops switching outside buck
// - No input overvoltage shutdown in buck
// - Compensation node connected only while dimming high
// - Dimming high enables switching; oscillator runs regardless
// - Dimming low stops regulation, switches high-impedance
// - Analog dimming compares level against internal ramp
// - Mode strap selects buck or buck-boost
// - Digital dimming passes pulse straight through
// - Thermal shutdown with hysteresis
// - LED short flagged after blanking expires
// - Blanking timer counts only while dimming high
// - Ground short latches off until power cycle
// - LED open detected on output overvoltage
// - Open latch holds until output falls low
// - Fault flag low on bias undervoltage
// - Fault flag low during thermal shutdown
// - Dimming rising edge restarts oscillator
module led_driver_protect_dim_ctrl #(
  parameter int PERIOD_NOM = led_ctrl_pkg::PERIOD_NOM_DEF,
  parameter int BLANK_CYCLES = led_ctrl_pkg::BLANK_CYCLES_DEF,
  parameter bit FAST_VARIANT = 1'b0
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic mode_strap_bb,
  input wire logic analog_dim_mode,
  input wire logic dimming_input,
  input wire logic [11:0] dim_level_mv,
  input wire logic [15:0] dim_rate_config,
  input wire led_ctrl_pkg::cmp_s cmp,
  output led_ctrl_pkg::gate_s gate,
  output logic comp_connect,
  output logic fault_flag_n,
  output logic mode_bb,
  output logic slope_proportional,
  output logic [11:0] slope_rate,
  output logic [15:0] sw_period
);
  import led_ctrl_pkg::*;

  if (BLANK_CYCLES < 1 || BLANK_CYCLES > 65535) begin : g_bad_blank
    $error("Blanking count out of range");
  end

  cmp_s cs;
  logic strap_done;
  logic vin_ok;
  logic ov_trip;
  logic tsd;
  logic [15:0] rate_cnt;
  logic [8:0] ramp_idx;
  logic [11:0] ramp_mv;
  logic dim_eff;
  logic dim_prev;
  logic dim_rise;
  logic [15:0] blank_cnt;
  logic blank_done;
  logic short_flag;
  logic gnd_short;
  logic open_latch;
  logic run;
  logic hs_latch;
  logic cycle_start;

  // ----------------------------------------------------------------
  // Comparator sampling
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cs <= '0;
    end else if (clk_en) begin
      cs <= cmp;
    end
  end

  // ----------------------------------------------------------------
  // Mode strap
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      strap_done <= 1'b0;
      mode_bb <= 1'b0;
    end else if (clk_en && !strap_done) begin
      strap_done <= 1'b1;
      mode_bb <= mode_strap_bb;
    end
  end

  // ----------------------------------------------------------------
  // Slope compensation select
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      slope_proportional <= 1'b0;
      slope_rate <= 12'h000;
    end else if (clk_en) begin
      slope_proportional <= mode_bb;
      if (mode_bb) begin
        slope_rate <= SLOPE_BB_PERMIL_PER_V;
      end else begin
        slope_rate <= FAST_VARIANT ? SLOPE_BUCK_FAST_MA_US : SLOPE_BUCK_SLOW_MA_US;
      end
    end
  end

  // ----------------------------------------------------------------
  // Input lockout, overvoltage and thermal hysteresis
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      vin_ok <= 1'b0;
    end else if (clk_en && strap_done) begin
      if (mode_bb) begin
        if (cs.vin_above_bb_on) begin
          vin_ok <= 1'b1;
        end else if (!cs.vin_above_bb_off) begin
          vin_ok <= 1'b0;
        end
      end else begin
        if (cs.vin_above_buck_on) begin
          vin_ok <= 1'b1;
        end else if (!cs.vin_above_buck_off) begin
          vin_ok <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ov_trip <= 1'b0;
    end else if (clk_en) begin
      if (!mode_bb) begin
        ov_trip <= 1'b0;
      end else if (cs.vin_above_ov_trip) begin
        ov_trip <= 1'b1;
      end else if (!cs.vin_above_ov_release) begin
        ov_trip <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      tsd <= 1'b0;
    end else if (clk_en) begin
      if (cs.temp_above_trip) begin
        tsd <= 1'b1;
      end else if (!cs.temp_above_release) begin
        tsd <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Dimming ramp and effective dimming signal
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rate_cnt <= 16'h0000;
      ramp_idx <= 9'h000;
    end else if (clk_en) begin
      if (rate_cnt >= dim_rate_config) begin
        rate_cnt <= 16'h0000;
        if (ramp_idx == 9'(DIM_STEPS - 1)) begin
          ramp_idx <= 9'h000;
        end else begin
          ramp_idx <= ramp_idx + 9'h001;
        end
      end else begin
        rate_cnt <= rate_cnt + 16'h0001;
      end
    end
  end

  assign ramp_mv = 12'(DIM_OFFSET_MV + int'(ramp_idx) * DIM_STEP_MV);

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      dim_eff <= 1'b0;
      dim_prev <= 1'b0;
    end else if (clk_en) begin
      dim_prev <= dim_eff;
      if (analog_dim_mode) begin
        dim_eff <= (dim_level_mv > ramp_mv);
      end else begin
        dim_eff <= dimming_input;
      end
    end
  end

  assign dim_rise = dim_eff && !dim_prev;

  // ----------------------------------------------------------------
  // Startup blanking timer
  // ----------------------------------------------------------------
  assign blank_done = (blank_cnt == 16'(BLANK_CYCLES));

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      blank_cnt <= 16'h0000;
    end else if (clk_en && dim_eff && !blank_done) begin
      blank_cnt <= blank_cnt + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Output faults
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      short_flag <= 1'b0;
    end else if (clk_en) begin
      short_flag <= cs.out_below_short && blank_done;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      gnd_short <= 1'b0;
    end else if (clk_en && cs.out_below_short && cs.comp_above_limit && blank_done) begin
      gnd_short <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      open_latch <= 1'b0;
    end else if (clk_en) begin
      if (cs.out_above_ov) begin
        open_latch <= 1'b1;
      end else if (cs.out_below_release) begin
        open_latch <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      fault_flag_n <= 1'b1;
    end else if (clk_en) begin
      fault_flag_n <= !(short_flag || gnd_short || open_latch
                        || cs.bias_uv || tsd);
    end
  end

  // ----------------------------------------------------------------
  // Switching permission and gates
  // ----------------------------------------------------------------
  assign run = vin_ok && !cs.bias_uv && !ov_trip && !tsd && !gnd_short
               && !open_latch && dim_eff;

  sw_osc #(
    .PERIOD_NOM(PERIOD_NOM)
  ) u_osc (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .restart(dim_rise),
    .cycle_start(cycle_start),
    .period(sw_period)
  );

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      hs_latch <= 1'b0;
    end else if (clk_en) begin
      if (cycle_start && run) begin
        hs_latch <= 1'b1;
      end else if (cs.hs_overcurrent || cs.pwm_trip || !run) begin
        hs_latch <= 1'b0;
      end
    end
  end

  assign gate.hs_on = hs_latch && run && !cs.hs_overcurrent;
  assign gate.ls_on = run && !hs_latch;
  assign gate.hi_z = !run;
  assign comp_connect = dim_eff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_bias_stop;
    @(posedge sys_clk) disable iff (!reset_n)
    cs.bias_uv |-> gate.hi_z && !gate.hs_on && !gate.ls_on;
  endproperty
  a_bias_stop: assert property (p_bias_stop)
    else $error("Switching while bias undervoltage");

  property p_dim_low_hiz;
    @(posedge sys_clk) disable iff (!reset_n)
    !dim_eff |-> gate.hi_z && !comp_connect;
  endproperty
  a_dim_low_hiz: assert property (p_dim_low_hiz)
    else $error("Dimming low but switches not off");

  property p_oc_kill;
    @(posedge sys_clk) disable iff (!reset_n)
    cs.hs_overcurrent |-> !gate.hs_on;
  endproperty
  a_oc_kill: assert property (p_oc_kill)
    else $error("High side on during overcurrent");

  property p_oc_hold;
    @(posedge sys_clk) disable iff (!reset_n)
    (clk_en && cs.hs_overcurrent && !cycle_start) |=> !hs_latch;
  endproperty
  a_oc_hold: assert property (p_oc_hold)
    else $error("High side kept after overcurrent");

  property p_gnd_latch;
    @(posedge sys_clk) disable iff (!reset_n)
    $rose(gnd_short) |=> gnd_short [*8];
  endproperty
  a_gnd_latch: assert property (p_gnd_latch)
    else $error("Ground short latch released");

  property p_ov_buck;
    @(posedge sys_clk) disable iff (!reset_n)
    (clk_en && !mode_bb) |=> !ov_trip;
  endproperty
  a_ov_buck: assert property (p_ov_buck)
    else $error("Overvoltage trip in buck mode");

  property p_blank_hold;
    @(posedge sys_clk) disable iff (!reset_n)
    !dim_eff |=> $stable(blank_cnt);
  endproperty
  a_blank_hold: assert property (p_blank_hold)
    else $error("Blanking timer moved while dimming low");

  property p_short_blank;
    @(posedge sys_clk) disable iff (!reset_n)
    (clk_en && short_flag) |-> blank_done ##1 !fault_flag_n;
  endproperty
  a_short_blank: assert property (p_short_blank)
    else $error("Short flagged before blanking expired");

  property p_tsd_flag;
    @(posedge sys_clk) disable iff (!reset_n)
    (clk_en && tsd) |=> !fault_flag_n;
  endproperty
  a_tsd_flag: assert property (p_tsd_flag)
    else $error("Fault flag high during thermal shutdown");

  property p_restart;
    @(posedge sys_clk) disable iff (!reset_n)
    (clk_en && dim_rise && run) |=> hs_latch;
  endproperty
  a_restart: assert property (p_restart)
    else $error("Oscillator not restarted on dimming rise");

endmodule : led_driver_protect_dim_ctrl

// ---- dv/led_stage_model.sv ----
// Behavioural analog stage: power switches, LED string and comparators.
// Assumes the bench holds levels in mV and degrees C between clock edges.
`timescale 1ns/1ps
module led_stage_model (
  input wire logic [15:0] vin_mv,
  input wire logic [7:0] temp_c,
  input wire logic bias_low,
  input wire logic [11:0] out_mv,
  input wire logic [11:0] comp_mv,
  input wire logic oc_req,
  input wire logic pwm_req,
  input wire led_ctrl_pkg::gate_s gate,
  output led_ctrl_pkg::cmp_s cmp
);
  import led_ctrl_pkg::*;
  // ----------------------------------------------------------------
  // Threshold comparators
  // ----------------------------------------------------------------
  always_comb begin
    cmp.bias_uv = bias_low;
    cmp.vin_above_bb_on = vin_mv > 16'h1194;
    cmp.vin_above_bb_off = vin_mv > 16'h0fa0;
    cmp.vin_above_buck_on = vin_mv > 16'h1f40;
    cmp.vin_above_buck_off = vin_mv > 16'h1e46;
    cmp.vin_above_ov_trip = vin_mv > 16'h86c4;
    cmp.vin_above_ov_release = vin_mv > 16'h8214;
    cmp.temp_above_trip = temp_c > 8'ha5;
    cmp.temp_above_release = temp_c > 8'h9b;
    cmp.hs_overcurrent = gate.hs_on & oc_req;
    cmp.pwm_trip = gate.hs_on & pwm_req;
    cmp.out_below_short = out_mv < 12'h096;
    cmp.comp_above_limit = comp_mv > 12'hd48;
    cmp.out_above_ov = out_mv > 12'hbb8;
    cmp.out_below_release = out_mv < 12'hb54;
  end
endmodule : led_stage_model

// ---- dv/led_driver_protect_dim_ctrl_tb_top.sv ----
// Self-checking bench for the LED driver protection and dimming sequencer.
// Assumes the analog stage model feeds every comparator input.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
  compares++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); \
  end \
end
module led_driver_protect_dim_ctrl_tb_top;
  import led_ctrl_pkg::*;
  localparam int PN = 20;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic mode_strap_bb = 1'b0;
  logic analog_dim_mode = 1'b0;
  logic dimming_input = 1'b1;
  logic [11:0] dim_level_mv = 12'h000;
  logic [15:0] dim_rate_config = 16'h0001;
  logic [15:0] vin_mv = 16'h2ee0;
  logic [7:0] temp_c = 8'h19;
  logic bias_low = 1'b0;
  logic [11:0] out_mv = 12'h3e8;
  logic [11:0] comp_mv = 12'h3e8;
  logic oc_req = 1'b0;
  logic pwm_req = 1'b0;
  cmp_s cmp;
  gate_s gate;
  logic comp_connect;
  logic fault_flag_n;
  logic mode_bb;
  logic slope_proportional;
  logic [11:0] slope_rate;
  logic [15:0] sw_period;
  int mismatches = 0;
  int compares = 0;

  always #12.5 sys_clk = ~sys_clk;

  led_stage_model i_stage (.vin_mv(vin_mv), .temp_c(temp_c), .bias_low(bias_low),
    .out_mv(out_mv), .comp_mv(comp_mv), .oc_req(oc_req), .pwm_req(pwm_req), .gate(gate),
    .cmp(cmp));

  led_driver_protect_dim_ctrl #(.PERIOD_NOM(PN), .BLANK_CYCLES(50), .FAST_VARIANT(1'b0)) i_dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en), .mode_strap_bb(mode_strap_bb),
    .analog_dim_mode(analog_dim_mode), .dimming_input(dimming_input),
    .dim_level_mv(dim_level_mv), .dim_rate_config(dim_rate_config), .cmp(cmp),
    .gate(gate), .comp_connect(comp_connect), .fault_flag_n(fault_flag_n),
    .mode_bb(mode_bb), .slope_proportional(slope_proportional), .slope_rate(slope_rate),
    .sw_period(sw_period));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task give_verdict;
    if (mismatches == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  task step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : step

  task do_reset(input logic bb);
    @(posedge sys_clk);
    reset_n <= 1'b0;
    mode_strap_bb <= bb;
    step(6);
    `CHK("reset gate", 3'b001, gate)
    `CHK("reset flag", 1'b1, fault_flag_n)
    @(posedge sys_clk);
    reset_n <= 1'b1;
    step(3);
  endtask : do_reset

  task wait_hs(input int n);
    int i;
    for (i = 0; i < n && gate.hs_on !== 1'b1; i++) step(1);
    `CHK("hs_on wait", 1'b1, gate.hs_on)
    if (gate.hs_on !== 1'b1) begin
      give_verdict;
    end
  endtask : wait_hs

  task vin(input logic [15:0] mv);
    @(posedge sys_clk);
    vin_mv <= mv;
    step(5);
  endtask : vin

  task outc(input logic [11:0] o, input logic [11:0] c);
    @(posedge sys_clk);
    out_mv <= o;
    comp_mv <= c;
    step(5);
  endtask : outc

  task dim(input logic v, input int n);
    @(posedge sys_clk);
    dimming_input <= v;
    step(n);
  endtask : dim

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_buck;
    `CHK("mode_bb", 1'b0, mode_bb)
    `CHK("slope_prop", 1'b0, slope_proportional)
    `CHK("slope_rate", SLOPE_BUCK_SLOW_MA_US, slope_rate)
    vin(16'h1edc);
    `CHK("hi_z 7.9 up", 1'b0, gate.hi_z)
    vin(16'h1e14);
    `CHK("hi_z 7.7", 1'b1, gate.hi_z)
    vin(16'h1edc);
    `CHK("hi_z 7.9 down", 1'b1, gate.hi_z)
    vin(16'h1fa4);
    `CHK("hi_z 8.1", 1'b0, gate.hi_z)
    vin(16'h8ca0);
    `CHK("hi_z 36 buck", 1'b0, gate.hi_z)
    vin(16'h2ee0);
  endtask : t_buck

  task t_bb;
    `CHK("mode_bb", 1'b1, mode_bb)
    `CHK("slope_prop", 1'b1, slope_proportional)
    `CHK("slope_rate", SLOPE_BB_PERMIL_PER_V, slope_rate)
    vin(16'h1068);
    `CHK("hi_z 4.2 up", 1'b0, gate.hi_z)
    vin(16'h0f3c);
    `CHK("hi_z 3.9", 1'b1, gate.hi_z)
    vin(16'h1068);
    `CHK("hi_z 4.2 down", 1'b1, gate.hi_z)
    vin(16'h11f8);
    `CHK("hi_z 4.6", 1'b0, gate.hi_z)
    vin(16'h88b8);
    `CHK("gate ov", 3'b001, gate)
    vin(16'h84d0);
    `CHK("hi_z 34", 1'b1, gate.hi_z)
    vin(16'h80e8);
    `CHK("hi_z 33", 1'b0, gate.hi_z)
  endtask : t_bb

  task t_dimming;
    dim(1'b0, 3);
    `CHK("gate dim low", 3'b001, gate)
    `CHK("comp dim low", 1'b0, comp_connect)
    @(posedge sys_clk);
    clk_en <= 1'b0;
    dimming_input <= 1'b1;
    step(4);
    `CHK("comp frozen", 1'b0, comp_connect)
    @(posedge sys_clk);
    clk_en <= 1'b1;
    wait_hs(3);
    `CHK("comp dim high", 1'b1, comp_connect)
  endtask : t_dimming

  task t_bias;
    @(posedge sys_clk);
    bias_low <= 1'b1;
    step(5);
    `CHK("hi_z bias", 1'b1, gate.hi_z)
    `CHK("flag bias", 1'b0, fault_flag_n)
    @(posedge sys_clk);
    bias_low <= 1'b0;
    step(5);
    `CHK("flag bias off", 1'b1, fault_flag_n)
    `CHK("hi_z bias off", 1'b0, gate.hi_z)
  endtask : t_bias

  task t_thermal;
    logic [7:0] tv [3] = '{8'haa, 8'ha0, 8'h96};
    logic [1:0] ex [3] = '{2'b10, 2'b10, 2'b01};
    int k;
    for (k = 0; k < 3; k++) begin
      @(posedge sys_clk);
      temp_c <= tv[k];
      step(5);
      `CHK("hi_z and flag", ex[k], {gate.hi_z, fault_flag_n})
    end
  endtask : t_thermal

  task t_overcurrent;
    dim(1'b0, 3);
    dim(1'b1, 0);
    wait_hs(3);
    @(posedge sys_clk);
    oc_req <= 1'b1;
    step(1);
    `CHK("gate oc", 3'b000, gate)
    step(1);
    `CHK("gate oc low side", 3'b010, gate)
    @(posedge sys_clk);
    oc_req <= 1'b0;
    wait_hs(50);
    @(posedge sys_clk);
    pwm_req <= 1'b1;
    step(2);
    `CHK("gate pwm trip", 3'b010, gate)
    @(posedge sys_clk);
    pwm_req <= 1'b0;
  endtask : t_overcurrent

  task t_open;
    outc(12'hc1c, 12'h3e8);
    `CHK("open", 2'b10, {gate.hi_z, fault_flag_n})
    outc(12'hb86, 12'h3e8);
    `CHK("open held", 2'b10, {gate.hi_z, fault_flag_n})
    outc(12'haf0, 12'h3e8);
    `CHK("open freed", 2'b01, {gate.hi_z, fault_flag_n})
  endtask : t_open

  task t_sweep;
    logic [15:0] lo;
    logic [15:0] hi;
    lo = 16'hffff;
    hi = 16'h0000;
    repeat (11000) begin
      step(1);
      if (sw_period < lo) lo = sw_period;
      if (sw_period > hi) hi = sw_period;
    end
    `CHK("sweep low", 1'b1, lo >= PN * SWEEP_LO_PCT / 100 && lo <= PN * SWEEP_LO_PCT / 100 + 1)
    `CHK("sweep high", 1'b1, hi >= PN * SWEEP_HI_PCT / 100 && hi <= PN * SWEEP_HI_PCT / 100 + 1)
  endtask : t_sweep

  task t_analog;
    logic [11:0] lv [3] = '{12'h064, 12'hc1c, 12'h645};
    int ex [3] = '{0, 560, 280};
    int k;
    int n;
    for (k = 0; k < 3; k++) begin
      @(posedge sys_clk);
      analog_dim_mode <= 1'b1;
      dim_level_mv <= lv[k];
      step(5);
      n = 0;
      repeat (560) begin
        step(1);
        n += comp_connect;
      end
      `CHK("analog duty", 1'b1, n >= ex[k] - 8 && n <= ex[k] + 8)
    end
    @(posedge sys_clk);
    analog_dim_mode <= 1'b0;
    step(3);
  endtask : t_analog

  task t_blank;
    dim(1'b0, 1);
    do_reset(1'b0);
    outc(12'h064, 12'h3e8);
    dim(1'b1, 40);
    `CHK("flag blanked", 1'b1, fault_flag_n)
    dim(1'b0, 30);
    `CHK("flag held", 1'b1, fault_flag_n)
    dim(1'b1, 20);
    `CHK("flag short", 1'b0, fault_flag_n)
    outc(12'h3e8, 12'h3e8);
    `CHK("flag short gone", 1'b1, fault_flag_n)
    outc(12'h064, 12'hdac);
    `CHK("gnd short", 2'b10, {gate.hi_z, fault_flag_n})
    outc(12'h3e8, 12'h3e8);
    `CHK("gnd short held", 2'b10, {gate.hi_z, fault_flag_n})
  endtask : t_blank

  initial begin
    do_reset(1'b0);
    t_buck;
    t_dimming;
    t_bias;
    t_thermal;
    t_overcurrent;
    t_open;
    t_sweep;
    t_analog;
    do_reset(1'b1);
    t_bb;
    t_blank;
    give_verdict;
  end
endmodule : led_driver_protect_dim_ctrl_tb_top
